// ===== hw/rse_pkg.sv
`default_nettype none
package rse_pkg;

	// instruction word layout
	localparam int unsigned  INSTR_W        = 14;
	localparam int unsigned  DATA_W         = 8;
	localparam int unsigned  ADDR_W         = 7;
	localparam int unsigned  DEST_BIT       = 7;
	localparam int unsigned  OPC_HI         = 13;
	localparam int unsigned  OPC_LO         = 8;
	localparam logic [5:0]   OPC_ROT_LEFT   = 6'h0d;
	localparam logic [5:0]   OPC_ROT_RIGHT  = 6'h0c;
	localparam logic [13:0]  INSTR_SLEEP    = 14'h0063;
	localparam logic [7:0]   WDOG_CLEAR_VAL = 8'h00;
	// reset values
	localparam logic [7:0]   W_RST          = 8'h00;
	localparam logic         CARRY_RST      = 1'b0;
	localparam logic         TIMEOUT_RST    = 1'b1;
	localparam logic         PWRDN_RST      = 1'b1;

	typedef enum logic [1:0] {
		RSE_OP_NONE,
		RSE_OP_ROT_LEFT,
		RSE_OP_ROT_RIGHT,
		RSE_OP_SLEEP
	} rse_op_t;

	// decoded view of one instruction word
	typedef struct packed {
		rse_op_t     op;
		logic        dest_file;
		logic [6:0]  addr;
	} rse_dec_t;

	// write-back request to the register file
	typedef struct packed {
		logic        we;
		logic [6:0]  addr;
		logic [7:0]  data;
	} rse_fwr_t;

endpackage : rse_pkg
`default_nettype wire

// ===== hw/rse_decode.sv
`timescale 1ns/1ps
`default_nettype none
module rse_decode (
	input  wire logic [13:0]        instr,
	output var  rse_pkg::rse_dec_t  dec
);
	// pure decode, one word, no operand fetch beyond the word itself
	always_comb begin
		dec.dest_file = instr[rse_pkg::DEST_BIT];
		dec.addr      = instr[rse_pkg::ADDR_W-1:0];
		if (instr[rse_pkg::OPC_HI:rse_pkg::OPC_LO] == rse_pkg::OPC_ROT_LEFT) begin
			dec.op = rse_pkg::RSE_OP_ROT_LEFT;
		end else if (instr[rse_pkg::OPC_HI:rse_pkg::OPC_LO] == rse_pkg::OPC_ROT_RIGHT) begin
			dec.op = rse_pkg::RSE_OP_ROT_RIGHT;
		end else if (instr == rse_pkg::INSTR_SLEEP) begin
			dec.op = rse_pkg::RSE_OP_SLEEP;
		end else begin
			dec.op = rse_pkg::RSE_OP_NONE;
		end
	end
endmodule : rse_decode
`default_nettype wire

// ===== hw/rse_exec.sv
// Contract
// - rotate left: bits move up, carry into bit 0, bit 7 to carry
// - rotate left result to working register if dest 0, else file
// - rotate right: bits move down, carry into bit 7, bit 0 to carry
// - rotate right result to working register if dest 0, else file
// - rotates decoded by opcode 001101/001100, dest bit, 7-bit address
// - power-down decoded from fixed word 0x0063, one cycle
// - power-down clears watchdog, sets timeout, clears powerdown, sleeps
`timescale 1ns/1ps
`default_nettype none
module rse_exec (
	input  wire logic         CORE_CLK,
	input  wire logic         RST_B,
	input  wire logic         INSTR_VALID,
	input  wire logic [13:0]  INSTR,
	input  wire logic [7:0]   FILE_RDATA,
	input  wire logic         WAKE,
	output logic      [6:0]   FILE_RADDR,
	output logic              FILE_WE,
	output logic      [6:0]   FILE_WADDR,
	output logic      [7:0]   FILE_WDATA,
	output logic      [7:0]   W_REG,
	output logic              CARRY,
	output logic              TIMEOUT_FLAG,
	output logic              POWERDOWN_FLAG,
	output logic              WATCHDOG_CLR,
	output logic              SLEEPING
);
	// all state in one register, written only by the always_ff below
	typedef struct packed {
		rse_pkg::rse_fwr_t  fwr;
		logic [7:0]         w;
		logic               carry;
		logic               timeout;
		logic               pwrdn;
		logic               wdog_clr;
		logic               sleep;
	} rse_state_t;

	rse_state_t         st_q;
	rse_state_t         st_d;
	rse_pkg::rse_dec_t  dec;
	logic [7:0]         rot;
	logic               rot_c;
	logic               go;

	rse_decode u_dec (
		.instr (INSTR),
		.dec   (dec)
	);

	// the file read is combinational on the address field, so the operand
	// is present in the same cycle; a sleeping core executes nothing
	assign FILE_RADDR = dec.addr;
	assign go         = INSTR_VALID && !st_q.sleep;

	// rotate datapath; carry is the registered flag, so back-to-back
	// rotates chain through it with no bypass needed
	always_comb begin
		rot   = FILE_RDATA;
		rot_c = st_q.carry;
		unique case (dec.op)
			rse_pkg::RSE_OP_ROT_LEFT: begin
				rot   = {FILE_RDATA[6:0], st_q.carry};
				rot_c = FILE_RDATA[7];
			end
			rse_pkg::RSE_OP_ROT_RIGHT: begin
				rot   = {st_q.carry, FILE_RDATA[7:1]};
				rot_c = FILE_RDATA[0];
			end
			rse_pkg::RSE_OP_SLEEP, rse_pkg::RSE_OP_NONE: begin
				rot   = FILE_RDATA;
				rot_c = st_q.carry;
			end
		endcase
	end

	// next state: every action completes in the cycle it is issued
	always_comb begin
		st_d          = st_q;
		st_d.fwr.we   = 1'h0;
		st_d.wdog_clr = 1'h0;
		// wake is external, it only ever ends sleep; go is low while asleep,
		// so a wake and a new power-down can never meet in one cycle
		if (st_q.sleep && WAKE) begin
			st_d.sleep = 1'h0;
		end
		if (go) begin
			unique case (dec.op)
				rse_pkg::RSE_OP_ROT_LEFT, rse_pkg::RSE_OP_ROT_RIGHT: begin
					st_d.carry = rot_c;
					if (dec.dest_file) begin
						st_d.fwr.we   = 1'h1;
						st_d.fwr.addr = dec.addr;
						st_d.fwr.data = rot;
					end else begin
						st_d.w = rot;
					end
				end
				rse_pkg::RSE_OP_SLEEP: begin
					st_d.wdog_clr = 1'h1;
					st_d.timeout  = 1'h1;
					st_d.pwrdn    = 1'h0;
					st_d.sleep    = 1'h1;
				end
				// unknown words change nothing
				rse_pkg::RSE_OP_NONE: begin
					st_d.w = st_q.w;
				end
			endcase
		end
	end

	// reset loads constants only, so the write strobe and the watchdog
	// pulse stay low until the first edge after release
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			st_q.fwr.we   <= 1'h0;
			st_q.fwr.addr <= 7'h00;
			st_q.fwr.data <= 8'h00;
			st_q.w        <= rse_pkg::W_RST;
			st_q.carry    <= rse_pkg::CARRY_RST;
			st_q.timeout  <= rse_pkg::TIMEOUT_RST;
			st_q.pwrdn    <= rse_pkg::PWRDN_RST;
			st_q.wdog_clr <= 1'h0;
			st_q.sleep    <= 1'h0;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs straight from the state register
	assign FILE_WE        = st_q.fwr.we;
	assign FILE_WADDR     = st_q.fwr.addr;
	assign FILE_WDATA     = st_q.fwr.data;
	assign W_REG          = st_q.w;
	assign CARRY          = st_q.carry;
	assign TIMEOUT_FLAG   = st_q.timeout;
	assign POWERDOWN_FLAG = st_q.pwrdn;
	assign WATCHDOG_CLR   = st_q.wdog_clr;
	assign SLEEPING       = st_q.sleep;

	// rotate checks: result, carry and destination one edge after issue
	rot_left_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		go && dec.op == rse_pkg::RSE_OP_ROT_LEFT |=>
		CARRY == $past(FILE_RDATA[7]))
		else $error("rotate left carry wrong");
	rot_right_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		go && dec.op == rse_pkg::RSE_OP_ROT_RIGHT && !dec.dest_file |=>
		W_REG == {$past(CARRY), $past(FILE_RDATA[7:1])} && CARRY == $past(FILE_RDATA[0]))
		else $error("rotate right result wrong");
	left_dest_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		go && dec.op == rse_pkg::RSE_OP_ROT_LEFT && dec.dest_file |=>
		FILE_WE && FILE_WDATA == {$past(FILE_RDATA[6:0]), $past(CARRY)} && $stable(W_REG))
		else $error("rotate left file write wrong");
	right_dest_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		go && dec.op == rse_pkg::RSE_OP_ROT_RIGHT && dec.dest_file |=>
		FILE_WE && FILE_WADDR == $past(INSTR[6:0]))
		else $error("rotate right file write wrong");
	left_wreg_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		go && dec.op == rse_pkg::RSE_OP_ROT_LEFT && !dec.dest_file |=>
		W_REG == {$past(FILE_RDATA[6:0]), $past(CARRY)} && !FILE_WE)
		else $error("rotate left working register wrong");
	left_addr_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		go && dec.op == rse_pkg::RSE_OP_ROT_LEFT && dec.dest_file |=>
		FILE_WADDR == $past(INSTR[6:0]))
		else $error("rotate left file address wrong");
	right_data_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		go && dec.op == rse_pkg::RSE_OP_ROT_RIGHT && dec.dest_file |=>
		FILE_WDATA == {$past(CARRY), $past(FILE_RDATA[7:1])} && $stable(W_REG))
		else $error("rotate right file data wrong");
	// of the flags, only the carry may move on a rotate
	rot_flags_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		go && (dec.op == rse_pkg::RSE_OP_ROT_LEFT ||
		dec.op == rse_pkg::RSE_OP_ROT_RIGHT) |=>
		$stable(TIMEOUT_FLAG) && $stable(POWERDOWN_FLAG) && !WATCHDOG_CLR)
		else $error("rotate touched a flag other than carry");
	// decode checks
	rot_decode_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		INSTR[13:8] == 6'h0d |-> dec.op == rse_pkg::RSE_OP_ROT_LEFT)
		else $error("rotate left not decoded");
	right_decode_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		INSTR[13:8] == 6'h0c |-> dec.op == rse_pkg::RSE_OP_ROT_RIGHT)
		else $error("rotate right not decoded");
	sleep_match_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		INSTR == 14'h0063 |-> dec.op == rse_pkg::RSE_OP_SLEEP)
		else $error("power-down word not decoded");
	// a word that decodes to nothing must leave W_REG and CARRY alone and raise no strobe
	idle_word_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		go && dec.op == rse_pkg::RSE_OP_NONE |=>
		$stable(W_REG) && $stable(CARRY) && !FILE_WE && !WATCHDOG_CLR)
		else $error("unknown word changed state");
	// power-down checks
	sleep_decode_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		go && INSTR == 14'h0063 |=> SLEEPING && WATCHDOG_CLR)
		else $error("sleep not executed in one cycle");
	sleep_flags_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		go && dec.op == rse_pkg::RSE_OP_SLEEP |=>
		TIMEOUT_FLAG && !POWERDOWN_FLAG ##1 !WATCHDOG_CLR)
		else $error("sleep flags wrong");
	// a sleeping core ignores every word until the wake input
	sleep_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		SLEEPING && !WAKE |=> SLEEPING && !FILE_WE && $stable(W_REG) && $stable(CARRY))
		else $error("sleeping core changed state");
	wake_exit_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		SLEEPING && WAKE |=> !SLEEPING && !FILE_WE)
		else $error("wake did not end sleep");
	// only a rotate to the file may raise the write strobe
	no_write_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		!go || dec.op == rse_pkg::RSE_OP_SLEEP || dec.op == rse_pkg::RSE_OP_NONE ||
		!dec.dest_file |=> !FILE_WE)
		else $error("file write without rotate");
	// coverage of the main scenarios
	cov_left_c: cover property (@(posedge CORE_CLK) go && dec.op == rse_pkg::RSE_OP_ROT_LEFT);
	cov_right_c: cover property (@(posedge CORE_CLK) go && dec.op == rse_pkg::RSE_OP_ROT_RIGHT);
	cov_sleep_c: cover property (@(posedge CORE_CLK) go && dec.op == rse_pkg::RSE_OP_SLEEP);
	cov_wake_c: cover property (@(posedge CORE_CLK) SLEEPING ##1 !SLEEPING);
	cov_file_c: cover property (@(posedge CORE_CLK) FILE_WE ##1 FILE_WE);
endmodule : rse_exec
`default_nettype wire

// ===== tb/rse_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rse_exec_tb;
	logic        CORE_CLK, RST_B, INSTR_VALID, WAKE, FILE_WE, CARRY;
	logic        TIMEOUT_FLAG, POWERDOWN_FLAG, WATCHDOG_CLR, SLEEPING;
	logic [13:0] INSTR;
	logic [7:0]  FILE_RDATA, FILE_WDATA, W_REG;
	logic [6:0]  FILE_RADDR, FILE_WADDR;
	int          failures, num_checks;
	// expected state, advanced one instruction at a time
	logic [7:0]  e_w, e_wd;
	logic [6:0]  e_wa;
	logic        e_c, e_we, e_tmo, e_pwr, e_clr, e_slp;
	logic [13:0] ins;

	rse_exec dut (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
		.FILE_RDATA(FILE_RDATA), .WAKE(WAKE), .FILE_RADDR(FILE_RADDR), .FILE_WE(FILE_WE),
		.FILE_WADDR(FILE_WADDR), .FILE_WDATA(FILE_WDATA), .W_REG(W_REG), .CARRY(CARRY),
		.TIMEOUT_FLAG(TIMEOUT_FLAG), .POWERDOWN_FLAG(POWERDOWN_FLAG),
		.WATCHDOG_CLR(WATCHDOG_CLR), .SLEEPING(SLEEPING));

	// 10 mhz core clock
	initial begin : clk_gen
		CORE_CLK = 1'b0;
		forever #50 CORE_CLK = ~CORE_CLK;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// returns {new carry, result}
	function automatic logic [8:0] rot(input logic left, input logic [7:0] d, input logic c);
		return left ? {d, c} : {d[0], c, d[7:1]};
	endfunction : rot

	task automatic cmp_all;
		chk(16'({FILE_WE, FILE_WADDR, FILE_WDATA}), 16'({e_we, e_wa, e_wd}));
		chk(16'({W_REG, CARRY}), 16'({e_w, e_c}));
		chk(16'({TIMEOUT_FLAG, POWERDOWN_FLAG}), 16'({e_tmo, e_pwr}));
		chk(16'({WATCHDOG_CLR, SLEEPING}), 16'({e_clr, e_slp}));
	endtask : cmp_all

	// drive at the falling edge, compare one falling edge later
	task automatic step(input logic v, input logic [13:0] i, input logic [7:0] d, input logic wk);
		logic [8:0] r;
		INSTR_VALID = v;
		INSTR = i;
		FILE_RDATA = d;
		WAKE = wk;
		#1 chk(16'(FILE_RADDR), 16'(i[6:0]));
		e_we = 1'h0;
		e_clr = 1'h0;
		if (e_slp) e_slp = !wk;
		else if (v && (i[13:8] == rse_pkg::OPC_ROT_LEFT || i[13:8] == rse_pkg::OPC_ROT_RIGHT)) begin
			r = rot(i[13:8] == rse_pkg::OPC_ROT_LEFT, d, e_c);
			e_c = r[8];
			if (i[rse_pkg::DEST_BIT]) {e_we, e_wa, e_wd} = {1'h1, i[6:0], r[7:0]};
			else e_w = r[7:0];
		end else if (v && i == rse_pkg::INSTR_SLEEP) {e_clr, e_tmo, e_pwr, e_slp} = 4'hd;
		@(negedge CORE_CLK);
		cmp_all();
	endtask : step

	// reset may also land mid-run; the model restarts with it
	task automatic rst;
		RST_B = 1'h0;
		repeat (5) @(negedge CORE_CLK);
		{e_w, e_wd, e_wa, e_c, e_we, e_clr, e_slp} = 27'h0;
		{e_tmo, e_pwr} = 2'h3;
		cmp_all();
		RST_B = 1'h1;
	endtask : rst

	task automatic close_out;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : close_out

	// corner cases first, then random words biased toward the decoded ones
	initial begin : main
		{INSTR_VALID, WAKE, INSTR, FILE_RDATA} = 24'h0;
		RST_B = 1'h0;
		failures = 0;
		num_checks = 0;
		void'($urandom(32'h8b414ac9));
		rst();
		step(1'h1, 14'h0d85, 8'he6, 1'h0);
		step(1'h1, 14'h0c05, 8'he6, 1'h0);
		step(1'h1, 14'h0dff, 8'h80, 1'h0);
		step(1'h1, 14'h0c00, 8'h01, 1'h0);
		step(1'h1, rse_pkg::INSTR_SLEEP, 8'h00, 1'h0);
		step(1'h1, 14'h0d85, 8'hff, 1'h0);
		step(1'h0, 14'h0000, 8'h00, 1'h1);
		for (int n = 0; n < 3000; n++) begin
			if (n == 1500) rst();
			case ($urandom % 4)
				0: ins = {rse_pkg::OPC_ROT_LEFT, 8'($urandom)};
				1: ins = {rse_pkg::OPC_ROT_RIGHT, 8'($urandom)};
				2: ins = rse_pkg::INSTR_SLEEP;
				default: ins = 14'($urandom);
			endcase
			step(($urandom % 8) != 0, ins, 8'($urandom), ($urandom % 4) == 0);
		end
		close_out();
	end

	// a hang costs at most about 4000 cycles
	initial begin : watchdog
		#400000;
		failures++;
		close_out();
	end
endmodule : rse_exec_tb
`default_nettype wire
